// [power_monitor_alert_cfg.svh]
`ifndef POWER_MONITOR_ALERT_CFG_SVH
`define POWER_MONITOR_ALERT_CFG_SVH

// Command codes
`define MON_CONTROL_ADDR 8'hd3
`define MON_SAMPLING_CONFIG_ADDR 8'hd4
`define FIRST_ALERT_PIN_CONFIG_ADDR 8'hd5

// Reset values
`define MON_CONTROL_RESET 1'h1
`define MON_SAMPLING_CONFIG_RESET 8'h8f
`define FIRST_ALERT_PIN_CONFIG_RESET 16'h8000
`define PIN_IDLE_LEVEL 1'h1

// Sampling config fields
`define SAMPLING_MODE_BIT 7
`define AUX_SAMPLE_BIT 6
`define SAMPLING_RSVD_BIT 5
`define SENSE_RANGE_MSB 4
`define SENSE_RANGE_LSB 3
`define AVERAGING_MSB 2
`define AVERAGING_LSB 0

// Alert pin config fields
`define ALERT_EN_MSB 15
`define ALERT_EN_LSB 3
`define OUTPUT_FUNCTION_MSB 2
`define OUTPUT_FUNCTION_LSB 1
`define OUTPUT_POLARITY_BIT 0

`endif

// [power_monitor_alert_pkg.sv]
package power_monitor_alert_pkg;

	// Bit order matches the enable field, bit 15 down to bit 3
	typedef struct packed {
		logic fet_bad_flag;
		logic overcurrent_fault_flag;
		logic input_overvolt_fault_flag;
		logic input_undervolt_fault_flag;
		logic comm_fault_flag;
		logic overcurrent_warn_flag;
		logic second_current_warn_flag;
		logic input_overvolt_warn_flag;
		logic input_undervolt_warn_flag;
		logic aux_overvolt_warn_flag;
		logic aux_undervolt_warn_flag;
		logic current_limit_fault_flag;
		logic overpower_warn_flag;
	} flags_t;

	typedef struct packed {
		logic wr_en;
		logic rd_en;
		logic [7:0] addr;
		logic [15:0] wr_data;
	} reg_req_t;

	typedef enum logic [1:0] {
		FUNC_ALERT = 2'h0,
		FUNC_SOFTWARE = 2'h1,
		FUNC_CONVERSION_TRIGGER_INPUT_INPUT = 2'h2,
		FUNC_COMPARATOR = 2'h3
	} output_function_t;

endpackage

// [power_monitor_alert_config.sv]
`timescale 1ns/1ps
`include "power_monitor_alert_cfg.svh"
// Operation
// - Sampling mode: 0 single-shot, 1 continuous, reset 1
// - Single-shot run bit self-clears; continuous needs write
// - Aux sample enable adds aux voltage, reset 0
// - Range 01 is 25 mV, 10 is 50 mV
// - Averaging 0 none, else 2^code samples, reset 111
// - FET-bad alert enable resets to one
// - Overcurrent fault enable gates alert, reset 0
// - Input overvoltage fault enable gates alert
// - Input undervoltage fault enable gates alert
// - Comm error enable gates alert
// - Overcurrent warning enable gates alert
// - Second current warning enable gates alert
// - Input over/undervoltage warning enables gate alert
// - Aux over/undervoltage warning enables gate alert
// - Current-limit fault enable gates alert
// - Overpower warning enable gates alert
// - Function 00 alert, 01 software, 10 trigger
// - Function 11 follows live enabled flags
// - Software mode polarity: 0 low, 1 high
module power_monitor_alert_config #(
	parameter logic [1:0] DEFAULT_SENSE_RANGE = 2'h1
) (
	input wire logic clk,
	input wire logic resetn,
	input wire power_monitor_alert_pkg::reg_req_t req,
	output logic [15:0] rd_data,
	input wire power_monitor_alert_pkg::flags_t latched_flags,
	input wire power_monitor_alert_pkg::flags_t live_flags,
	input wire logic sample_cycle_done,
	output logic monitor_run,
	output logic sampling_mode_sel,
	output logic aux_sample_en,
	output logic [1:0] sense_range_sel,
	output logic [2:0] averaging_sel,
	input wire logic first_general_output_pin_in,
	output logic first_general_output_pin_out,
	output logic first_general_output_pin_oe_n,
	output logic conversion_trigger_pulse
);

	// Only the two sense ranges are legal reset values
	if (DEFAULT_SENSE_RANGE != 2'h1 && DEFAULT_SENSE_RANGE != 2'h2) begin : g_bad_range
		$error("DEFAULT_SENSE_RANGE must be 01 or 10");
	end

	// Mode, aux and reserved bits from the reset word, variant range, averaging
	localparam logic [7:0] SAMPLING_RESET = {3'(`MON_SAMPLING_CONFIG_RESET >> 5), DEFAULT_SENSE_RANGE,
		3'(`MON_SAMPLING_CONFIG_RESET)};
	localparam int FLAG_COUNT = $bits(power_monitor_alert_pkg::flags_t);

	if (FLAG_COUNT != `ALERT_EN_MSB - `ALERT_EN_LSB + 1) begin : g_bad_flags
		$error("flag set and enable field differ in width");
	end

	logic run;
	logic [7:0] sampling_cfg;
	logic [15:0] alert_cfg;
	logic trig_meta;
	logic trig_sync;
	logic trig_prev;

	// Decode
	wire sel_control = req.addr == `MON_CONTROL_ADDR;
	wire sel_sampling = req.addr == `MON_SAMPLING_CONFIG_ADDR;
	wire sel_alert = req.addr == `FIRST_ALERT_PIN_CONFIG_ADDR;
	wire wr_control = req.wr_en && sel_control;
	wire wr_sampling = req.wr_en && sel_sampling;
	wire wr_alert = req.wr_en && sel_alert;
	wire single_shot = !sampling_cfg[`SAMPLING_MODE_BIT];
	wire [12:0] alert_en = alert_cfg[`ALERT_EN_MSB:`ALERT_EN_LSB];
	wire power_monitor_alert_pkg::output_function_t out_func =
		power_monitor_alert_pkg::output_function_t'(alert_cfg[`OUTPUT_FUNCTION_MSB:`OUTPUT_FUNCTION_LSB]);
	wire polarity = alert_cfg[`OUTPUT_POLARITY_BIT];
	wire alert_mode = out_func == power_monitor_alert_pkg::FUNC_ALERT;
	wire power_monitor_alert_pkg::flags_t alert_mask = power_monitor_alert_pkg::flags_t'(alert_en);
	logic [FLAG_COUNT-1:0] latched_gate;
	logic [FLAG_COUNT-1:0] live_gate;
	// One latched and one live gate per status source
	for (genvar f = 0; f < FLAG_COUNT; f++) begin : g_flag_gate
		assign latched_gate[f] = latched_flags[f] && alert_en[f];
		assign live_gate[f] = live_flags[f] && alert_en[f];
	end
	wire latched_hit = |latched_gate;
	wire live_hit = |live_gate;
	// Rising pin edge counts only in trigger mode
	wire trig_edge = trig_sync && !trig_prev && out_func == power_monitor_alert_pkg::FUNC_CONVERSION_TRIGGER_INPUT_INPUT;

	// Bit 5 of the sampling config is stored but reads as zero
	wire [15:0] next_rd_data = sel_control ? {15'h0000, run} :
		sel_sampling ? {8'h00, sampling_cfg & ~(8'h01 << `SAMPLING_RSVD_BIT)} :
		sel_alert ? alert_cfg : 16'h0000;

	// Software write wins over the self-clear in the same cycle
	wire next_run = wr_control ? req.wr_data[0] :
		trig_edge ? 1'b1 :
		(single_shot && sample_cycle_done) ? 1'b0 : run;

	// Pin level per function; alert active means pulled low
	logic next_drive_low;
	always_comb begin
		case (out_func)
			power_monitor_alert_pkg::FUNC_ALERT: next_drive_low = latched_hit;
			power_monitor_alert_pkg::FUNC_SOFTWARE: next_drive_low = !polarity;
			power_monitor_alert_pkg::FUNC_CONVERSION_TRIGGER_INPUT_INPUT: next_drive_low = 1'b0;
			power_monitor_alert_pkg::FUNC_COMPARATOR: next_drive_low = live_hit;
			default: next_drive_low = 1'b0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			run <= `MON_CONTROL_RESET;
		end else begin
			run <= next_run;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			sampling_cfg <= SAMPLING_RESET;
		end else if (wr_sampling) begin
			sampling_cfg <= req.wr_data[7:0];
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			alert_cfg <= `FIRST_ALERT_PIN_CONFIG_RESET;
		end else if (wr_alert) begin
			alert_cfg <= req.wr_data;
		end
	end

	// Read data stands until the next read strobe
	always_ff @(posedge clk) begin
		if (!resetn) begin
			rd_data <= 16'h0000;
		end else if (req.rd_en) begin
			rd_data <= next_rd_data;
		end
	end

	// Synchroniser resets to the pulled-up idle level, so no false edge
	always_ff @(posedge clk) begin
		if (!resetn) begin
			trig_meta <= `PIN_IDLE_LEVEL;
			trig_sync <= `PIN_IDLE_LEVEL;
			trig_prev <= `PIN_IDLE_LEVEL;
		end else begin
			trig_meta <= first_general_output_pin_in;
			trig_sync <= trig_meta;
			trig_prev <= trig_sync;
		end
	end

	// Open-drain pin: only ever pulls low
	always_ff @(posedge clk) begin
		if (!resetn) begin
			first_general_output_pin_out <= 1'b0;
			first_general_output_pin_oe_n <= 1'b1;
			conversion_trigger_pulse <= 1'b0;
		end else begin
			first_general_output_pin_out <= 1'b0;
			first_general_output_pin_oe_n <= !next_drive_low;
			conversion_trigger_pulse <= trig_edge;
		end
	end

	assign monitor_run = run;
	assign sampling_mode_sel = sampling_cfg[`SAMPLING_MODE_BIT];
	assign aux_sample_en = sampling_cfg[`AUX_SAMPLE_BIT];
	assign sense_range_sel = sampling_cfg[`SENSE_RANGE_MSB:`SENSE_RANGE_LSB];
	assign averaging_sel = sampling_cfg[`AVERAGING_MSB:`AVERAGING_LSB];

	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);

	chk_reset_values: assert property (@(posedge clk) disable iff (1'b0) !resetn |=>
		sampling_cfg == SAMPLING_RESET && alert_cfg == 16'h8000 && run)
		else $error("reset values wrong");
	chk_single_clear: assert property (single_shot && run && sample_cycle_done && !wr_control && !trig_edge
		|=> !monitor_run)
		else $error("single-shot run bit did not clear");
	chk_cont_hold: assert property (!single_shot && run && !wr_control |=> monitor_run)
		else $error("continuous run bit dropped");
	chk_alert_latch: assert property (out_func == power_monitor_alert_pkg::FUNC_ALERT && latched_hit
		|=> !first_general_output_pin_oe_n)
		else $error("alert not asserted");
	chk_alert_idle: assert property (out_func == power_monitor_alert_pkg::FUNC_ALERT && !latched_hit
		|=> first_general_output_pin_oe_n)
		else $error("alert asserted without enabled flag");
	chk_fet_default: assert property (alert_cfg == 16'h8000 && latched_flags.fet_bad_flag
		|=> !first_general_output_pin_oe_n)
		else $error("fet alert missing at default");
	chk_cmp_live: assert property (out_func == power_monitor_alert_pkg::FUNC_COMPARATOR
		|=> first_general_output_pin_oe_n == !$past(live_hit))
		else $error("comparator output wrong");
	chk_gpo_polarity: assert property (out_func == power_monitor_alert_pkg::FUNC_SOFTWARE
		|=> first_general_output_pin_oe_n == $past(polarity))
		else $error("software output level wrong");
	chk_conversion_trigger_input_release: assert property (out_func == power_monitor_alert_pkg::FUNC_CONVERSION_TRIGGER_INPUT_INPUT
		|=> first_general_output_pin_oe_n)
		else $error("pin driven in trigger mode");
	chk_rsvd_read: assert property (req.rd_en && sel_sampling |=> rd_data[5] == 1'b0)
		else $error("reserved bit read nonzero");

	// Each enable routes its own latched flag to the alert
	chk_ocf_route: assert property (alert_mode && alert_mask.overcurrent_fault_flag
		&& latched_flags.overcurrent_fault_flag |=> !first_general_output_pin_oe_n)
		else $error("overcurrent fault alert missing");
	chk_iof_route: assert property (alert_mode && alert_mask.input_overvolt_fault_flag
		&& latched_flags.input_overvolt_fault_flag |=> !first_general_output_pin_oe_n)
		else $error("input overvoltage fault alert missing");
	chk_iuf_route: assert property (alert_mode && alert_mask.input_undervolt_fault_flag
		&& latched_flags.input_undervolt_fault_flag |=> !first_general_output_pin_oe_n)
		else $error("input undervoltage fault alert missing");
	chk_comm_route: assert property (alert_mode && alert_mask.comm_fault_flag
		&& latched_flags.comm_fault_flag |=> !first_general_output_pin_oe_n)
		else $error("communication fault alert missing");
	chk_ocw_route: assert property (alert_mode && alert_mask.overcurrent_warn_flag
		&& latched_flags.overcurrent_warn_flag |=> !first_general_output_pin_oe_n)
		else $error("overcurrent warning alert missing");
	chk_scw_route: assert property (alert_mode && alert_mask.second_current_warn_flag
		&& latched_flags.second_current_warn_flag |=> !first_general_output_pin_oe_n)
		else $error("second current warning alert missing");
	chk_iow_route: assert property (alert_mode && alert_mask.input_overvolt_warn_flag
		&& latched_flags.input_overvolt_warn_flag |=> !first_general_output_pin_oe_n)
		else $error("input overvoltage warning alert missing");
	chk_iuw_route: assert property (alert_mode && alert_mask.input_undervolt_warn_flag
		&& latched_flags.input_undervolt_warn_flag |=> !first_general_output_pin_oe_n)
		else $error("input undervoltage warning alert missing");
	chk_aow_route: assert property (alert_mode && alert_mask.aux_overvolt_warn_flag
		&& latched_flags.aux_overvolt_warn_flag |=> !first_general_output_pin_oe_n)
		else $error("aux overvoltage warning alert missing");
	chk_auw_route: assert property (alert_mode && alert_mask.aux_undervolt_warn_flag
		&& latched_flags.aux_undervolt_warn_flag |=> !first_general_output_pin_oe_n)
		else $error("aux undervoltage warning alert missing");
	chk_clim_route: assert property (alert_mode && alert_mask.current_limit_fault_flag
		&& latched_flags.current_limit_fault_flag |=> !first_general_output_pin_oe_n)
		else $error("current limit alert missing");
	chk_opw_route: assert property (alert_mode && alert_mask.overpower_warn_flag
		&& latched_flags.overpower_warn_flag |=> !first_general_output_pin_oe_n)
		else $error("overpower warning alert missing");
	chk_fet_masked: assert property (alert_mode && !alert_mask.fet_bad_flag
		&& latched_flags == 13'h1000 |=> first_general_output_pin_oe_n)
		else $error("fet alert raised while disabled");

	chk_single_hold: assert property (single_shot && run && !sample_cycle_done && !wr_control |=> monitor_run)
		else $error("single-shot run bit cleared early");
	chk_write_wins: assert property (wr_control |=> monitor_run == $past(req.wr_data[0]))
		else $error("run bit write lost");
	chk_cont_stop: assert property (!single_shot && wr_control && !req.wr_data[0] |=> !monitor_run)
		else $error("continuous sampling not stopped");
	chk_run_read: assert property (req.rd_en && sel_control |=> rd_data == {15'h0000, $past(run)})
		else $error("run bit read wrong");
	chk_mode_write: assert property (wr_sampling |=>
		sampling_mode_sel == $past(req.wr_data[`SAMPLING_MODE_BIT])
		&& averaging_sel == $past(req.wr_data[`AVERAGING_MSB:`AVERAGING_LSB]))
		else $error("sampling mode or averaging write lost");
	chk_range_write: assert property (wr_sampling |=>
		aux_sample_en == $past(req.wr_data[`AUX_SAMPLE_BIT])
		&& sense_range_sel == $past(req.wr_data[`SENSE_RANGE_MSB:`SENSE_RANGE_LSB]))
		else $error("aux enable or sense range write lost");
	chk_aux_read: assert property (req.rd_en && sel_sampling |=> rd_data[`AUX_SAMPLE_BIT] == $past(aux_sample_en))
		else $error("aux enable read wrong");
	chk_alert_read: assert property (req.rd_en && sel_alert |=> rd_data == $past(alert_cfg))
		else $error("alert config read wrong");
	chk_unmapped_read: assert property (req.rd_en && !sel_control && !sel_sampling && !sel_alert
		|=> rd_data == 16'h0000)
		else $error("unmapped read nonzero");
	chk_read_hold: assert property (!req.rd_en |=> $stable(rd_data))
		else $error("read data changed without a read");
	chk_trig_pulse: assert property (trig_edge && !wr_control |=> conversion_trigger_pulse && monitor_run)
		else $error("trigger edge lost");
	chk_trig_only_conversion_trigger_input: assert property (conversion_trigger_pulse
		|-> $past(out_func) == power_monitor_alert_pkg::FUNC_CONVERSION_TRIGGER_INPUT_INPUT)
		else $error("trigger pulse outside trigger mode");
	chk_pin_open_drain: assert property (!first_general_output_pin_out)
		else $error("pin driven high");
	chk_cmp_quiet: assert property (out_func == power_monitor_alert_pkg::FUNC_COMPARATOR
		&& !(|(live_flags & alert_mask)) |=> first_general_output_pin_oe_n)
		else $error("comparator output without live flag");

	cov_alert: cover property (latched_hit ##1 !first_general_output_pin_oe_n);
	cov_single_done: cover property (single_shot && run && sample_cycle_done ##1 !run);
	cov_comparator: cover property (out_func == power_monitor_alert_pkg::FUNC_COMPARATOR && live_hit);
	cov_trigger: cover property (trig_edge ##1 conversion_trigger_pulse);
	cov_software: cover property (out_func == power_monitor_alert_pkg::FUNC_SOFTWARE ##1 !first_general_output_pin_oe_n);

endmodule

// [pmbus_host_model.sv]
`timescale 1ns/1ps
// Host side of the command-code port: one strobe per access, held for one edge
module pmbus_host_model (
	input wire logic clk,
	input wire logic [15:0] rd_data,
	output power_monitor_alert_pkg::reg_req_t req
);
	initial req = '0;
	task automatic access(input logic wr, input logic [7:0] a, input logic [15:0] d, output logic [15:0] q);
		@(negedge clk);
		req <= '{wr, !wr, a, d};
		@(negedge clk);
		req <= '0;
		// One more edge so the pin follows a new setting
		@(negedge clk);
		q = rd_data;
	endtask
endmodule

// [power_monitor_alert_config_test.sv]
`timescale 1ns/1ps
module power_monitor_alert_config_test;
	logic clk = 0;
	logic resetn = 0;
	power_monitor_alert_pkg::reg_req_t req;
	power_monitor_alert_pkg::flags_t latched = '0;
	power_monitor_alert_pkg::flags_t live = '0;
	logic done = 0;
	logic drive = 1;
	logic [15:0] rd_data, q;
	logic run, mode, aux, pin_out, oe_n, trig;
	logic [1:0] range;
	logic [2:0] avg;
	// Pulled up unless the block or drive pulls low
	wire pin = oe_n ? drive : 1'b0;
	int fail_count = 0;
	int cmp_count = 0;
	int cycles = 0;
	int trig_count = 0;
	initial forever #50 clk = ~clk;
	pmbus_host_model host_u (.clk(clk), .rd_data(rd_data), .req(req));
	power_monitor_alert_config #(.DEFAULT_SENSE_RANGE(2'h1)) dut_u (.clk(clk), .resetn(resetn), .req(req),
		.rd_data(rd_data), .latched_flags(latched), .live_flags(live), .sample_cycle_done(done),
		.monitor_run(run), .sampling_mode_sel(mode), .aux_sample_en(aux), .sense_range_sel(range),
		.averaging_sel(avg), .first_general_output_pin_in(pin), .first_general_output_pin_out(pin_out),
		.first_general_output_pin_oe_n(oe_n), .conversion_trigger_pulse(trig));
	task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic settle();
		repeat (2) @(negedge clk);
	endtask
	task automatic finish_test();
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	always @(negedge clk) begin
		cycles++;
		if (trig === 1'b1) trig_count++;
		if (cycles == 3000) begin
			fail_count++;
			finish_test();
		end
	end
	task automatic t_reset();
		host_u.access(0, 8'hd4, 16'h0000, q);
		check("sampling cfg", 16'h008f, q);
		host_u.access(0, 8'hd5, 16'h0000, q);
		check("alert cfg", 16'h8000, q);
		host_u.access(0, 8'h42, 16'h0000, q);
		check("unmapped", 16'h0000, q);
		check("run", 16'h1, run);
	endtask
	task automatic t_fet();
		latched = 13'h1000;
		settle();
		check("fet alert", 16'h0, oe_n);
		latched = '0;
		settle();
		check("fet released", 16'h1, oe_n);
	endtask
	task automatic t_enables();
		for (int i = 0; i < 13; i++) begin
			host_u.access(1, 8'hd5, 16'h0008 << i, q);
			latched = 13'h0001 << ((i + 1) % 13);
			settle();
			check("masked flag", 16'h1, oe_n);
			latched[i] = 1'b1;
			settle();
			check("enabled flag", 16'h0, oe_n);
			latched = '0;
		end
	endtask
	task automatic t_modes();
		host_u.access(1, 8'hd5, 16'h0002, q);
		check("sw low", 16'h0, oe_n);
		check("pin out low", 16'h0, pin_out);
		host_u.access(1, 8'hd5, 16'h0003, q);
		check("sw high", 16'h1, oe_n);
		host_u.access(1, 8'hd5, 16'h8006, q);
		latched = 13'h1000;
		settle();
		check("cmp latched only", 16'h1, oe_n);
		live = 13'h1000;
		settle();
		check("cmp live", 16'h0, oe_n);
		live = '0;
	endtask
	task automatic t_trigger();
		host_u.access(1, 8'hd3, 16'h0000, q);
		host_u.access(1, 8'hd5, 16'hfffc, q);
		latched = 13'h1fff;
		settle();
		check("trigger undriven", 16'h1, oe_n);
		trig_count = 0;
		drive = 0;
		repeat (3) @(negedge clk);
		drive = 1;
		repeat (6) @(negedge clk);
		check("trigger pulses", 16'h1, 16'(trig_count));
		check("trigger run", 16'h1, run);
		latched = '0;
	endtask
	task automatic t_single();
		host_u.access(1, 8'hd4, 16'h0076, q);
		host_u.access(1, 8'hd3, 16'h0001, q);
		host_u.access(0, 8'hd4, 16'h0000, q);
		check("sampling readback", 16'h0056, q);
		check("ports", {9'h0, 7'h36}, {9'h0, mode, aux, range, avg});
		done = 1;
		@(negedge clk);
		done = 0;
		@(negedge clk);
		check("single run", 16'h0, run);
		host_u.access(1, 8'hd4, 16'h008f, q);
		host_u.access(1, 8'hd3, 16'h0001, q);
		done = 1;
		@(negedge clk);
		done = 0;
		@(negedge clk);
		check("cont run", 16'h1, run);
	endtask
	task automatic t_midreset();
		host_u.access(1, 8'hd5, 16'h0002, q);
		host_u.access(1, 8'hd4, 16'h0000, q);
		host_u.access(1, 8'hd3, 16'h0000, q);
		host_u.access(0, 8'hd5, 16'h0000, q);
		check("alert cfg written", 16'h0002, q);
		resetn = 0;
		repeat (2) @(negedge clk);
		resetn = 1;
		check("reset read data", 16'h0, rd_data);
		check("reset pin", 16'h1, oe_n);
		check("reset pin out", 16'h0, pin_out);
		check("reset run", 16'h1, run);
		check("reset ports", {9'h0, 7'h4f}, {9'h0, mode, aux, range, avg});
		host_u.access(0, 8'hd5, 16'h0000, q);
		check("reset alert cfg", 16'h8000, q);
		host_u.access(0, 8'hd4, 16'h0000, q);
		check("reset sampling cfg", 16'h008f, q);
	endtask
	initial begin
		repeat (12) @(negedge clk);
		resetn = 1;
		t_reset();
		t_fet();
		t_enables();
		t_modes();
		t_trigger();
		t_single();
		t_midreset();
		finish_test();
	end
endmodule
